// [src/sei_defs.svh]
// Notes on behaviour
// (R1) 64-byte trace aligned after CR/LF, 22 first
// (R2) no CR/LF: captured order, no error
// (R3) valid trace ends with 0D then 0A
// (R4) first-column overhead bytes passed or set per byte
// (R5) M1 set sends programmed value, full byte
// (R6) new injection cancels every other injection
// (R7) single command inserts exactly one error
// (R8) B1 rate 2.5E-5 down to 0.1E-9
// (R9) B2 rate 1.0E-3 down to 0.1E-9
// (R10) B3 max 1.0E-4, payload max 1.0E-3
// (R11) rate injection continues until off or replaced
// (R12) rate means corrupted fraction of transmitted bits
// (R13) MS-REI one frame carries count 1..255
// (R14) timed MS-REI 0.1..9.9 s, active shown
// (R15) continuous MS-REI active until switched off
// (R16) random BER 1.0E-3..0.1E-9 over random channels
// (R17) selected-channel BER only into chosen channel
// (R18) recurring inject 0.1..9.9 s, wait 1.0..30.0 s
// (R19) single B1/B2 into one or all channels
// (R20) sent trace: message, nulls, then CR LF
// (R21) error spacing from transmitted-bit counter
`ifndef SEI_DEFS_SVH
`define SEI_DEFS_SVH
`define SEI_CLK_NS 25
`define SEI_TENTH_NS 100000000
`define SEI_TRACE_LEN 64
`define SEI_TRACE_MSG 62
`define SEI_TRACE_SHOW 22
`define SEI_CR 8'h0d
`define SEI_LF 8'h0a
`define SEI_NULL 8'h00
`define SEI_OH_ROWS 9
`define SEI_BITS_PER_BEAT 7'h08
`define SEI_FLIP_MASK 8'h01
`define SEI_MIN_M 7'h01
`define SEI_MIN_E 4'h9
`define SEI_B1_MAX_M 7'h19
`define SEI_B1_MAX_E 4'h5
`define SEI_B2_MAX_M 7'h0a
`define SEI_B2_MAX_E 4'h3
`define SEI_B3_MAX_M 7'h0a
`define SEI_B3_MAX_E 4'h4
`define SEI_PAY_MAX_M 7'h0a
`define SEI_PAY_MAX_E 4'h3
`define SEI_MANT_MAX 7'h63
`define SEI_DUR_MIN 9'h001
`define SEI_DUR_MAX 9'h063
`define SEI_WAIT_MIN 9'h00a
`define SEI_WAIT_MAX 9'h12c
`define SEI_LFSR_SEED 16'hace1
`endif

// [src/sei_pkg.sv]
package sei_pkg;
  typedef enum logic [2:0] {
    POS_NONE = 3'h0, POS_OH = 3'h1, POS_J0 = 3'h2, POS_B1 = 3'h3,
    POS_B2 = 3'h4, POS_M1 = 3'h5, POS_B3 = 3'h6, POS_PAY = 3'h7
  } sei_pos_t;
  typedef enum logic [2:0] {
    ERR_B1 = 3'h0, ERR_B2 = 3'h1, ERR_B3 = 3'h2, ERR_REI = 3'h3, ERR_PAY = 3'h4
  } sei_err_t;
  typedef enum logic [8:0] {
    OP_OFF = 9'h001, OP_SINGLE = 9'h002, OP_RATE = 9'h004, OP_REI_FRAME = 9'h008,
    OP_REI_TIMED = 9'h010, OP_REI_CONTINUOUS_INJECTION = 9'h020, OP_RANDOM = 9'h040,
    OP_CHAN = 9'h080, OP_RECUR = 9'h100
  } sei_op_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1, PH_INJ = 3'h2, PH_WAIT = 3'h4
  } sei_phase_t;
  typedef struct packed {
    logic [7:0] data;
    sei_pos_t pos;
    logic [3:0] row;
    logic [3:0] chan;
  } sei_beat_t;
  typedef struct packed {
    sei_op_t op;
    sei_err_t etype;
    logic all_chan;
    logic [3:0] chan;
    logic [6:0] mant;
    logic [3:0] expo;
    logic [7:0] rei_n;
    logic [8:0] dur;
    logic [8:0] wait_t;
  } sei_cmd_t;
endpackage

// [src/sei_skid_buf.sv]
`timescale 1ns/100ps
module sei_skid_buf #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  initial begin
    if (W < 1) $error("sei_skid_buf: W must be positive");
  end
  logic [W-1:0] mem_r [2];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] cnt_r;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data = mem_r[rptr_r];
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wptr_r <= ~wptr_r;
      if (pop) rptr_r <= ~rptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (push) mem_r[wptr_r] <= i_data;
  end
endmodule // sei_skid_buf

// [src/sei_tx_error_injector.sv]
`timescale 1ns/100ps
`include "sei_defs.svh"
module sei_tx_error_injector import sei_pkg::*; #(
  parameter int N_CHAN = 16,
  parameter int TENTH_CYC = `SEI_TENTH_NS / `SEI_CLK_NS
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // transmit stream in
  input wire logic i_valid,
  input wire sei_beat_t i_beat,
  output logic o_ready,
  // transmit stream out
  output logic o_valid,
  output sei_beat_t o_beat,
  input wire logic i_ready,
  // overhead override
  input wire logic [`SEI_OH_ROWS-1:0] i_oh_set,
  input wire logic [`SEI_OH_ROWS-1:0][7:0] i_oh_val,
  input wire logic i_m1_set,
  input wire logic [7:0] i_m1_val,
  // injection commands and status
  input wire logic i_cmd_valid,
  input wire sei_cmd_t i_cmd,
  output logic o_cmd_rejected,
  output logic o_inj_active,
  output logic o_rei_active,
  output logic o_recur_inject,
  output logic o_recur_wait,
  // transmitted trace
  input wire logic i_tx_tr_en,
  input wire logic i_tx_tr_wr,
  input wire logic [5:0] i_tx_tr_addr,
  input wire logic [7:0] i_tx_tr_data,
  input wire logic [5:0] i_tx_tr_len,
  // received trace capture
  input wire logic i_rx_tr_valid,
  input wire logic [7:0] i_rx_tr_byte,
  input wire logic [5:0] i_trace_idx,
  output logic [7:0] o_trace_byte,
  output logic o_trace_ready,
  output logic o_trace_found
);
  initial begin
    if (N_CHAN < 1 || N_CHAN > 16) $error("sei: N_CHAN must be 1..16");
    if (TENTH_CYC < 2) $error("sei: TENTH_CYC must be at least 2");
  end
  localparam int TW = $clog2(TENTH_CYC + 1);

  function automatic logic [63:0] pow10(input logic [4:0] e);
    logic [63:0] p;
    p = 64'h1;
    for (int k = 0; k < 16; k++) begin
      if (k < e) p = p * 64'd10;
    end
    return p;
  endfunction
  // mantissa in tenths: ma/10 * 10^-ea <= mb/10 * 10^-eb
  function automatic logic rate_le(input logic [6:0] ma, input logic [3:0] ea,
                                   input logic [6:0] mb, input logic [3:0] eb);
    return (64'(ma) * pow10({1'b0, eb})) <= (64'(mb) * pow10({1'b0, ea}));
  endfunction
  function automatic logic rate_ok(input logic [6:0] m, input logic [3:0] e,
                                   input logic [6:0] mx, input logic [3:0] ex);
    return (m != 7'h00) && (m <= `SEI_MANT_MAX) && rate_le(m, e, mx, ex) &&
           rate_le(`SEI_MIN_M, `SEI_MIN_E, m, e);
  endfunction
  function automatic sei_pos_t kind_of(input sei_err_t t);
    case (t)
      ERR_B1: return POS_B1;
      ERR_B2: return POS_B2;
      ERR_B3: return POS_B3;
      ERR_REI: return POS_M1;
      default: return POS_PAY;
    endcase
  endfunction
  function automatic logic type_rate_ok(input sei_err_t t, input logic [6:0] m,
                                        input logic [3:0] e);
    case (t)
      ERR_B1: return rate_ok(m, e, `SEI_B1_MAX_M, `SEI_B1_MAX_E); // see (R8)
      ERR_B2: return rate_ok(m, e, `SEI_B2_MAX_M, `SEI_B2_MAX_E); // see (R9)
      ERR_B3: return rate_ok(m, e, `SEI_B3_MAX_M, `SEI_B3_MAX_E); // see (R10)
      ERR_PAY: return rate_ok(m, e, `SEI_PAY_MAX_M, `SEI_PAY_MAX_E); // see (R10)
      default: return 1'b0;
    endcase
  endfunction

  sei_op_t mode_r;
  sei_phase_t phase_r;
  sei_err_t etype_r;
  sei_pos_t pend_kind_r;
  logic all_r;
  logic [3:0] chan_r;
  logic [6:0] mant_r;
  logic [3:0] expo_r;
  logic [7:0] rei_n_r, rei_once_r;
  logic [8:0] wait_r, dur_r, left_r;
  logic [TW-1:0] tenth_r;
  logic [39:0] acc_r;
  logic [15:0] pend_r, lfsr_r;
  logic rej_r;

  // command check
  wire dur_ok = i_cmd.dur >= `SEI_DUR_MIN && i_cmd.dur <= `SEI_DUR_MAX;
  wire wait_ok = i_cmd.wait_t >= `SEI_WAIT_MIN && i_cmd.wait_t <= `SEI_WAIT_MAX;
  wire rei_ok = i_cmd.rei_n != 8'h00; // see (R13)
  wire ber_ok = rate_ok(i_cmd.mant, i_cmd.expo, `SEI_B2_MAX_M, `SEI_B2_MAX_E);
  wire rate_cmd_ok = i_cmd.etype != ERR_REI && type_rate_ok(i_cmd.etype, i_cmd.mant, i_cmd.expo);
  wire chan_ok = 32'(i_cmd.chan) < N_CHAN;
  logic cmd_ok;
  always_comb begin
    cmd_ok = 1'b0;
    unique case (i_cmd.op)
      OP_OFF: cmd_ok = 1'b1;
      OP_SINGLE: cmd_ok = (i_cmd.etype <= ERR_PAY) && chan_ok;
      OP_RATE: cmd_ok = rate_cmd_ok && chan_ok;
      OP_REI_FRAME, OP_REI_CONTINUOUS_INJECTION: cmd_ok = rei_ok;
      OP_REI_TIMED: cmd_ok = rei_ok && dur_ok;
      OP_RANDOM: cmd_ok = ber_ok; // see (R16)
      OP_CHAN: cmd_ok = ber_ok && chan_ok; // see (R17)
      OP_RECUR: cmd_ok = dur_ok && wait_ok && chan_ok &&
                         (i_cmd.etype == ERR_REI ? rei_ok : rate_cmd_ok);
      default: cmd_ok = 1'b0;
    endcase
  end
  wire cmd_take = i_cmd_valid && cmd_ok;
  wire cmd_bad = i_cmd_valid && !cmd_ok;

  // stream side decode
  logic buf_ready;
  wire take = i_valid && buf_ready;
  wire inj_phase = mode_r == OP_RECUR && phase_r == PH_INJ;
  wire rate_run = mode_r == OP_RATE || mode_r == OP_RANDOM || mode_r == OP_CHAN ||
                  (inj_phase && etype_r != ERR_REI); // see (R11)
  wire rei_run = mode_r == OP_REI_TIMED || mode_r == OP_REI_CONTINUOUS_INJECTION ||
                 (inj_phase && etype_r == ERR_REI);
  wire [39:0] thr = 40'(pow10(5'(expo_r) + 5'h01));
  // each beat carries eight transmitted bits
  wire [39:0] acc_sum = acc_r + 40'(mant_r) * 40'(`SEI_BITS_PER_BEAT); // see (R12)
  wire rate_tick = rate_run && take && acc_sum >= thr; // see (R21)
  wire [3:0] rnd_chan = 4'(32'(lfsr_r[3:0]) % N_CHAN);
  wire [3:0] tgt_chan = mode_r == OP_RANDOM ? rnd_chan : chan_r; // see (R16) (R17)
  wire [15:0] all_mask = 16'((17'h1 << N_CHAN) - 17'h1);
  wire [15:0] tgt_mask = all_r ? all_mask : 16'h1 << tgt_chan; // see (R19)
  wire [15:0] beat_bit = 16'h1 << i_beat.chan;
  wire hit = i_beat.pos == pend_kind_r && (pend_r & beat_bit) != 16'h0;
  wire [15:0] pend_clr = (take && hit) ? beat_bit : 16'h0;
  wire [15:0] pend_set = rate_tick ? tgt_mask : 16'h0;
  wire is_m1 = i_beat.pos == POS_M1;
  wire is_oh = i_beat.pos == POS_OH && 32'(i_beat.row) < `SEI_OH_ROWS;
  wire is_j0 = i_beat.pos == POS_J0 && i_tx_tr_en;
  wire tenth_tick = 32'(tenth_r) == TENTH_CYC - 1;
  wire timed = mode_r == OP_REI_TIMED || mode_r == OP_RECUR;
  wire expire = timed && tenth_tick && left_r == 9'h001;

  // transmitted trace
  logic [7:0] tx_msg_r [`SEI_TRACE_MSG];
  logic [5:0] tx_pos_r;
  logic [7:0] j0_byte;
  always_comb begin
    if (tx_pos_r == 6'(`SEI_TRACE_MSG)) j0_byte = `SEI_CR; // see (R20)
    else if (tx_pos_r == 6'(`SEI_TRACE_MSG + 1)) j0_byte = `SEI_LF;
    else if (tx_pos_r < i_tx_tr_len) j0_byte = tx_msg_r[tx_pos_r];
    else j0_byte = `SEI_NULL;
  end

  // output byte selection
  wire [7:0] oh_byte = is_oh && i_oh_set[i_beat.row] ? i_oh_val[i_beat.row]
                                                     : i_beat.data; // see (R4)
  wire [7:0] m1_byte = rei_run ? rei_n_r : // see (R14) (R15)
                       rei_once_r != 8'h00 ? rei_once_r : // see (R13)
                       i_m1_set ? i_m1_val : i_beat.data; // see (R5)
  wire [7:0] base_byte = is_m1 ? m1_byte : is_j0 ? j0_byte : oh_byte;
  wire [7:0] out_byte = hit ? base_byte ^ `SEI_FLIP_MASK : base_byte; // see (R7)
  wire sei_beat_t push_beat = '{data: out_byte, pos: i_beat.pos, row: i_beat.row,
                                chan: i_beat.chan};

  sei_skid_buf #(.W($bits(sei_beat_t))) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_valid),
    .i_data(push_beat),
    .o_ready(buf_ready),
    .o_valid(o_valid),
    .o_data(o_beat),
    .i_ready(i_ready)
  );
  assign o_ready = buf_ready;

  // injection control
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mode_r <= OP_OFF;
      phase_r <= PH_IDLE;
      etype_r <= ERR_B1;
      pend_kind_r <= POS_NONE;
      {all_r, chan_r, mant_r, expo_r, rei_n_r, dur_r, wait_r} <= '0;
      rei_once_r <= 8'h00;
      pend_r <= 16'h0;
      acc_r <= 40'h0;
      tenth_r <= '0;
      left_r <= 9'h000;
      rej_r <= 1'b0;
    end else if (cmd_take) begin
      // any accepted command replaces what ran before
      mode_r <= i_cmd.op == OP_SINGLE || i_cmd.op == OP_REI_FRAME ? OP_OFF : i_cmd.op;
      phase_r <= i_cmd.op == OP_RECUR ? PH_INJ : PH_IDLE; // see (R18)
      etype_r <= i_cmd.etype;
      pend_kind_r <= i_cmd.op == OP_RANDOM || i_cmd.op == OP_CHAN ? POS_PAY
                                                                  : kind_of(i_cmd.etype);
      all_r <= i_cmd.all_chan && i_cmd.op != OP_RANDOM && i_cmd.op != OP_CHAN;
      {chan_r, mant_r, expo_r} <= {i_cmd.chan, i_cmd.mant, i_cmd.expo};
      {rei_n_r, dur_r, wait_r} <= {i_cmd.rei_n, i_cmd.dur, i_cmd.wait_t};
      rei_once_r <= i_cmd.op == OP_REI_FRAME ? i_cmd.rei_n : // see (R13)
                    (i_cmd.op == OP_SINGLE && i_cmd.etype == ERR_REI) ? 8'h01 : 8'h00;
      pend_r <= (i_cmd.op == OP_SINGLE && i_cmd.etype != ERR_REI) ? // see (R6) (R7)
                (i_cmd.all_chan ? all_mask : 16'h1 << i_cmd.chan) : 16'h0; // see (R19)
      acc_r <= 40'h0;
      tenth_r <= '0;
      left_r <= i_cmd.dur;
      rej_r <= 1'b0;
    end else begin
      rej_r <= cmd_bad;
      pend_r <= (pend_r & ~pend_clr) | pend_set;
      if (take && is_m1) rei_once_r <= 8'h00;
      if (take && rate_run) acc_r <= rate_tick ? acc_sum - thr : acc_sum; // see (R21)
      tenth_r <= tenth_tick ? '0 : tenth_r + TW'(1);
      if (timed && tenth_tick) begin
        left_r <= left_r - 9'h001;
        if (expire && mode_r == OP_REI_TIMED) mode_r <= OP_OFF; // see (R14)
        if (expire && phase_r == PH_INJ) begin
          phase_r <= PH_WAIT; // see (R18)
          left_r <= wait_r;
          acc_r <= 40'h0;
        end
        if (expire && phase_r == PH_WAIT) begin
          phase_r <= PH_INJ;
          left_r <= dur_r;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) lfsr_r <= `SEI_LFSR_SEED;
    else if (rate_tick) lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) tx_pos_r <= 6'h00;
    else if (take && is_j0) tx_pos_r <= tx_pos_r == 6'(`SEI_TRACE_LEN - 1) ? 6'h00 : tx_pos_r + 6'h01;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_tx_tr_wr && 32'(i_tx_tr_addr) < `SEI_TRACE_MSG) tx_msg_r[i_tx_tr_addr] <= i_tx_tr_data;
  end

  assign o_cmd_rejected = rej_r;
  assign o_inj_active = mode_r != OP_OFF || pend_r != 16'h0 || rei_once_r != 8'h00;
  assign o_rei_active = rei_run;
  assign o_recur_inject = inj_phase;
  assign o_recur_wait = mode_r == OP_RECUR && phase_r == PH_WAIT;

  // received trace capture and alignment
  logic [7:0] cap_r [`SEI_TRACE_LEN];
  logic [5:0] wptr_r, scan_r, start_r;
  logic scanning_r, found_r, ready_r;
  logic [7:0] rd_r;
  wire [5:0] scan_nx = scan_r + 6'h01;
  wire pair = cap_r[scan_r] == `SEI_CR && cap_r[scan_nx] == `SEI_LF;
  always_ff @(posedge i_ref_clk) begin
    if (i_rx_tr_valid) cap_r[wptr_r] <= i_rx_tr_byte;
  end
  // a fresh 64-byte block restarts the search; the 64-cycle scan is far
  // shorter than one trace repetition, so the block is stable meanwhile
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wptr_r <= 6'h00;
      scan_r <= 6'h00;
      start_r <= 6'h00;
      scanning_r <= 1'b0;
      found_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      if (i_rx_tr_valid) wptr_r <= wptr_r + 6'h01;
      if (i_rx_tr_valid && wptr_r == 6'(`SEI_TRACE_LEN - 1)) begin
        scanning_r <= 1'b1;
        scan_r <= 6'h00;
        found_r <= 1'b0;
        start_r <= 6'h00; // see (R2)
      end else if (scanning_r) begin
        scan_r <= scan_nx;
        if (pair && !found_r) begin
          found_r <= 1'b1;
          start_r <= scan_r + 6'h02; // see (R1) (R3)
        end
        if (scan_r == 6'(`SEI_TRACE_LEN - 1)) begin
          scanning_r <= 1'b0;
          ready_r <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) rd_r <= 8'h00;
    else rd_r <= cap_r[6'(start_r + i_trace_idx)]; // see (R1)
  end
  assign o_trace_byte = rd_r;
  assign o_trace_ready = ready_r && !scanning_r;
  assign o_trace_found = found_r;

  // checks
  sequence s_last_tenth;
    timed && tenth_tick && left_r == 9'h001;
  endsequence
  a_m1_set_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R5)
    take && is_m1 && i_m1_set && !rei_run && rei_once_r == 8'h00 && !hit
    |-> push_beat.data == i_m1_val) else $error("M1 set value not sent");
  a_oh_set_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R4)
    take && is_oh && i_oh_set[i_beat.row] && !hit |-> push_beat.data == i_oh_val[i_beat.row])
    else $error("overhead set value not sent");
  a_cmd_cancel_all: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R6)
    cmd_take && i_cmd.op != OP_SINGLE && i_cmd.op != OP_REI_FRAME
    |=> pend_r == 16'h0 && rei_once_r == 8'h00 && acc_r == 40'h0)
    else $error("earlier injection survived new command");
  a_single_one_err: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R7)
    cmd_take && i_cmd.op == OP_SINGLE && !i_cmd.all_chan && i_cmd.etype != ERR_REI
    |=> $onehot(pend_r) && mode_r == OP_OFF) else $error("single inject not one error");
  a_b1_rate_limit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R8)
    i_cmd_valid && i_cmd.op == OP_RATE && i_cmd.etype == ERR_B1 &&
    !rate_le(i_cmd.mant, i_cmd.expo, `SEI_B1_MAX_M, `SEI_B1_MAX_E)
    |=> o_cmd_rejected && $stable(mode_r)) else $error("B1 rate above limit taken");
  a_rei_continuous_injection_act: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R15)
    mode_r == OP_REI_CONTINUOUS_INJECTION ##0 !i_cmd_valid [*2] |-> o_rei_active [*2])
    else $error("continuous MS-REI dropped");
  a_recur_phase_sw: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R18)
    s_last_tenth ##0 phase_r == PH_INJ && !i_cmd_valid |=> o_recur_wait && left_r == wait_r)
    else $error("recurring inject did not turn to wait");
  a_rate_spacing: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R21)
    rate_tick && !i_cmd_valid |=> acc_r < thr && (pend_r & $past(tgt_mask)) != 16'h0)
    else $error("rate tick did not arm an error");
  a_trace_tail: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R3)
    o_trace_ready && found_r && i_trace_idx == 6'(`SEI_TRACE_LEN - 2) && !i_rx_tr_valid
    |=> o_trace_byte == `SEI_CR) else $error("aligned trace not ending in CR");
  a_trace_noalign: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see (R2)
    o_trace_ready && !found_r |-> start_r == 6'h00) else $error("unaligned trace reordered");
endmodule // sei_tx_error_injector

// [tb/sei_ne_model.sv]
`timescale 1ns/100ps
module sei_ne_model import sei_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // stream from the injector
  input wire logic i_valid,
  input wire sei_beat_t i_beat,
  output logic o_ready,
  // stall request from the bench
  input wire logic i_stall
);
  sei_beat_t rx_q[$];
  // ready moves only between sampling edges
  always @(negedge i_ref_clk) o_ready <= i_rst_n && !i_stall;
  always @(posedge i_ref_clk) begin
    if (i_valid && o_ready) begin
      rx_q.push_back(i_beat);
    end
  end
endmodule // sei_ne_model

// [tb/tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top import sei_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready, out_valid, ne_ready, rej, inj_act, rei_act, rc_inj, rc_wait;
  logic stall = 1'b0;
  sei_beat_t in_beat = '0;
  sei_beat_t out_beat, got;
  logic [8:0] oh_set = '0;
  logic [8:0][7:0] oh_val = '0;
  logic m1_set = 1'b0;
  logic [7:0] m1_val = 8'h00;
  logic cmd_valid = 1'b0;
  sei_cmd_t cmd = '0;
  logic tr_en = 1'b0;
  logic tr_wr = 1'b0;
  logic [5:0] tr_addr = '0;
  logic [5:0] tr_len = '0;
  logic [5:0] idx = '0;
  logic [7:0] tr_data = '0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_byte = '0;
  logic [7:0] tr_byte;
  logic tr_rdy, tr_found;
  int errors = 0;
  int tests_run = 0;

  initial forever #12.5 clk = ~clk;

  sei_tx_error_injector #(.N_CHAN(16), .TENTH_CYC(20)) i_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_valid(in_valid), .i_beat(in_beat),
    .o_ready(in_ready), .o_valid(out_valid), .o_beat(out_beat), .i_ready(ne_ready),
    .i_oh_set(oh_set), .i_oh_val(oh_val), .i_m1_set(m1_set), .i_m1_val(m1_val),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_rejected(rej), .o_inj_active(inj_act),
    .o_rei_active(rei_act), .o_recur_inject(rc_inj), .o_recur_wait(rc_wait),
    .i_tx_tr_en(tr_en), .i_tx_tr_wr(tr_wr), .i_tx_tr_addr(tr_addr),
    .i_tx_tr_data(tr_data), .i_tx_tr_len(tr_len), .i_rx_tr_valid(rx_valid),
    .i_rx_tr_byte(rx_byte), .i_trace_idx(idx), .o_trace_byte(tr_byte),
    .o_trace_ready(tr_rdy), .o_trace_found(tr_found));

  sei_ne_model i_ne (.i_ref_clk(clk), .i_rst_n(rst_n), .i_valid(out_valid),
    .i_beat(out_beat), .o_ready(ne_ready), .i_stall(stall));

  task automatic close_out();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic timeout(input string nm);
    errors++;
    $display("unexpected wait %s expected done seen timeout", nm);
    close_out();
  endtask

  task automatic send(input logic [7:0] d, input sei_pos_t p, input logic [3:0] r, c);
    int n = 0;
    @(negedge clk);
    in_valid = 1'b1;
    in_beat = '{data: d, pos: p, row: r, chan: c};
    while (!in_ready && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) timeout("ready");
    @(posedge clk);
    @(negedge clk);
    in_valid = 1'b0;
  endtask

  task automatic get(output sei_beat_t b);
    int n = 0;
    while (i_ne.rx_q.size() == 0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) timeout("beat");
    b = i_ne.rx_q.pop_front();
  endtask

  task automatic xfer(input logic [7:0] d, input sei_pos_t p, input logic [3:0] r, c,
                      output logic [7:0] q);
    send(d, p, r, c);
    get(got);
    q = got.data;
  endtask

  function automatic sei_cmd_t mk(sei_op_t op, sei_err_t et, logic [6:0] m, logic [3:0] e);
    sei_cmd_t c;
    c = '{op: op, etype: et, all_chan: 1'b0, chan: 4'h0, mant: m, expo: e,
          rei_n: 8'h01, dur: 9'h001, wait_t: 9'h00a};
    return c;
  endfunction

  task automatic cmd_go(input sei_cmd_t c, input logic ex_rej, input string nm);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    `CHK(nm, ex_rej, rej)
  endtask

  task automatic t_tx_trace();
    logic [7:0] q[64];
    @(negedge clk);
    tr_wr = 1'b1;
    tr_data = 8'h41;
    tr_len = 6'h01;
    tr_en = 1'b1;
    @(negedge clk);
    tr_wr = 1'b0;
    for (int i = 0; i < 64; i++) begin
      xfer(8'hee, POS_J0, 4'h0, 4'h0, q[i]);
    end
    `CHK("tx msg", 8'h41, q[0])
    `CHK("tx pad", 8'h00, q[61])
    `CHK("tx cr", 8'h0d, q[62])
    `CHK("tx lf", 8'h0a, q[63])
    tr_en = 1'b0;
  endtask

  task automatic t_single();
    logic [7:0] q;
    sei_cmd_t c;
    cmd_go(mk(OP_SINGLE, ERR_B1, 7'h0a, 4'h3), 1'b0, "single");
    `CHK("pending", 1'b1, inj_act)
    xfer(8'h55, POS_B1, 4'h0, 4'h0, q);
    `CHK("b1 flip", 8'h54, q)
    xfer(8'h55, POS_B1, 4'h0, 4'h0, q);
    `CHK("b1 once", 8'h55, q)
    `CHK("done", 1'b0, inj_act)
    c = mk(OP_SINGLE, ERR_B2, 7'h0a, 4'h3);
    c.all_chan = 1'b1;
    cmd_go(c, 1'b0, "all chan");
    xfer(8'h10, POS_B2, 4'h0, 4'h3, q);
    `CHK("b2 ch3", 8'h11, q)
    xfer(8'h10, POS_B2, 4'h0, 4'h9, q);
    `CHK("b2 ch9", 8'h11, q)
  endtask

  task automatic t_overhead();
    logic [7:0] q;
    oh_set[3] = 1'b1;
    oh_val[3] = 8'h5a;
    m1_set = 1'b1;
    m1_val = 8'hff;
    xfer(8'h00, POS_OH, 4'h3, 4'h0, q);
    `CHK("oh set", 8'h5a, q)
    xfer(8'h11, POS_OH, 4'h4, 4'h0, q);
    `CHK("oh pass", 8'h11, q)
    xfer(8'h12, POS_M1, 4'h0, 4'h0, q);
    `CHK("m1 ff", 8'hff, q)
    m1_val = 8'h00;
    xfer(8'h12, POS_M1, 4'h0, 4'h0, q);
    `CHK("m1 00", 8'h00, q)
    m1_set = 1'b0;
    xfer(8'h12, POS_M1, 4'h0, 4'h0, q);
    `CHK("m1 pass", 8'h12, q)
  endtask

  task automatic t_rei();
    logic [7:0] q;
    sei_cmd_t c;
    c = mk(OP_REI_FRAME, ERR_REI, 7'h0a, 4'h3);
    c.rei_n = 8'hff;
    cmd_go(c, 1'b0, "rei frame");
    xfer(8'h00, POS_M1, 4'h0, 4'h0, q);
    `CHK("rei 255", 8'hff, q)
    xfer(8'h00, POS_M1, 4'h0, 4'h0, q);
    `CHK("rei one frame", 8'h00, q)
    c.rei_n = 8'h00;
    cmd_go(c, 1'b1, "rei zero");
    c = mk(OP_REI_CONTINUOUS_INJECTION, ERR_REI, 7'h0a, 4'h3);
    c.rei_n = 8'h02;
    cmd_go(c, 1'b0, "rei continuous_injection");
    `CHK("rei on", 1'b1, rei_act)
    for (int i = 0; i < 2; i++) begin
      xfer(8'h00, POS_M1, 4'h0, 4'h0, q);
      `CHK("rei each frame", 8'h02, q)
    end
    cmd_go(mk(OP_RATE, ERR_B1, 7'h01, 4'h9), 1'b0, "b1 min");
    `CHK("rei cancelled", 1'b0, rei_act)
    `CHK("rate on", 1'b1, inj_act)
    xfer(8'h33, POS_M1, 4'h0, 4'h0, q);
    `CHK("m1 after cancel", 8'h33, q)
    cmd_go(mk(OP_OFF, ERR_B1, 7'h0a, 4'h3), 1'b0, "off");
    `CHK("rate off", 1'b0, inj_act)
  endtask

  task automatic t_refuse();
    sei_err_t et[9] = '{ERR_B1, ERR_B1, ERR_B2, ERR_B2, ERR_B2, ERR_B3, ERR_B3, ERR_PAY,
                        ERR_PAY};
    logic [6:0] m[9] = '{7'h19, 7'h1a, 7'h0a, 7'h0b, 7'h01, 7'h0a, 7'h0b, 7'h0a, 7'h0b};
    logic [3:0] e[9] = '{4'h5, 4'h5, 4'h3, 4'h3, 4'ha, 4'h4, 4'h4, 4'h3, 4'h3};
    logic r[9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 9; i++) begin
      cmd_go(mk(OP_RATE, et[i], m[i], e[i]), r[i], "rate limit");
    end
  endtask

  task automatic t_rate();
    int cnt = 0;
    cmd_go(mk(OP_RATE, ERR_B2, 7'h0a, 4'h3), 1'b0, "b2 rate");
    i_ne.rx_q.delete();
    for (int i = 0; i < 1010; i++) begin
      send(8'h00, POS_B2, 4'h0, 4'h0);
    end
    tick(4);
    while (i_ne.rx_q.size() > 0) begin
      got = i_ne.rx_q.pop_front();
      cnt += int'(got.data[0]);
    end
    `CHK("b2 errors", 8, cnt)
    cmd_go(mk(OP_CHAN, ERR_PAY, 7'h0a, 4'h3), 1'b0, "chan");
    cmd_go(mk(OP_OFF, ERR_B1, 7'h0a, 4'h3), 1'b0, "off");
  endtask

  task automatic t_timed();
    sei_cmd_t c;
    cmd_go(mk(OP_REI_TIMED, ERR_REI, 7'h0a, 4'h3), 1'b0, "rei timed");
    tick(10);
    `CHK("timed on", 1'b1, rei_act)
    tick(20);
    `CHK("timed over", 1'b0, rei_act)
    c = mk(OP_RECUR, ERR_B1, 7'h19, 4'h5);
    c.wait_t = 9'h009;
    cmd_go(c, 1'b1, "wait short");
    c.wait_t = 9'h00a;
    cmd_go(c, 1'b0, "recur");
    `CHK("inject phase", 1'b1, rc_inj)
    tick(30);
    `CHK("wait phase", 1'b1, rc_wait)
    `CHK("inject ended", 1'b0, rc_inj)
    tick(200);
    `CHK("inject again", 1'b1, rc_inj)
    cmd_go(mk(OP_OFF, ERR_B1, 7'h0a, 4'h3), 1'b0, "off");
    `CHK("recur off", 1'b0, rc_inj | rc_wait)
  endtask

  task automatic t_buffer();
    stall = 1'b1;
    tick(2);
    send(8'ha1, POS_NONE, 4'h0, 4'h0);
    send(8'ha2, POS_NONE, 4'h0, 4'h0);
    `CHK("buf full", 1'b0, in_ready)
    `CHK("held", 1'b1, out_valid)
    stall = 1'b0;
    send(8'ha3, POS_NONE, 4'h0, 4'h0);
    for (int i = 0; i < 3; i++) begin
      get(got);
      `CHK("order", 8'ha1 + 8'(i), got.data)
    end
  endtask

  task automatic feed(input logic [7:0] base, input int cr);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = base + 8'(i);
      if (i == cr) rx_byte = 8'h0d;
      if (i == cr + 1) rx_byte = 8'h0a;
    end
    @(negedge clk);
    rx_valid = 1'b0;
  endtask

  task automatic rd(input logic [5:0] k, input logic [7:0] ex);
    @(negedge clk);
    idx = k;
    @(negedge clk);
    `CHK("trace byte", ex, tr_byte)
  endtask

  task automatic t_rx_trace();
    int n = 0;
    feed(8'h40, 10);
    while (tr_rdy !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) timeout("trace");
    `CHK("found", 1'b1, tr_found)
    rd(6'd0, 8'h4c);
    rd(6'd21, 8'h61);
    rd(6'd62, 8'h0d);
    rd(6'd63, 8'h0a);
    feed(8'h20, 99);
    tick(80);
    `CHK("not found", 1'b0, tr_found)
    rd(6'd0, 8'h20);
    rd(6'd63, 8'h5f);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK("rst valid", 1'b0, out_valid)
    `CHK("rst ready", 1'b1, in_ready)
    `CHK("rst active", 1'b0, inj_act)
    t_tx_trace();
    t_single();
    t_overhead();
    t_rei();
    t_refuse();
    t_rate();
    t_timed();
    t_buffer();
    t_rx_trace();
    close_out();
  end
endmodule // tb_top
